// *** bench/mode_wake_sva.sv ***
// port assertions for the mode and wakeup controller
// assumes one mclk domain and a synchronous active-low reset_n
module mode_wake_sva
  import mode_wake_pkg::*;
#(
  parameter int wake_cycles = wake_count_cycles
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic high_osc_run,
  input wire logic low_osc_run,
  input wire logic sys_clk_low_sel,
  input wire logic cpu_clk_en,
  input wire logic instr_strobe,
  input wire logic basic_timer_run,
  input wire logic timer_counter_a_run,
  input wire logic timer_counter_b_run,
  input wire logic watchdog_run,
  input wire logic port0_int
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // cycles spent warming the high oscillator after sleep
  logic [15:0] warm_cnt_r;
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !high_osc_run || low_osc_run)
      warm_cnt_r <= 16'h0;
    else
      warm_cnt_r <= warm_cnt_r + 16'h1;
  end

  // three quiet cycles after each instruction strobe
  sequence strobe_gap;
    cpu_clk_en ##1 !instr_strobe [*3];
  endsequence
  // cpu restarts straight out of the warmup
  sequence warm_exit;
    $rose(cpu_clk_en) && !$past(low_osc_run);
  endsequence

  AST_STROBE_DIV: assert property (instr_strobe |-> strobe_gap)
    else $error("instruction strobe spacing wrong");
  AST_SLOW_CLK: assert property (sys_clk_low_sel |-> low_osc_run)
    else $error("slow clock selected without low oscillator");
  AST_HI_STOP: assert property (!high_osc_run && low_osc_run |-> sys_clk_low_sel)
    else $error("high oscillator stopped while in use");
  AST_GREEN_TMR: assert property (low_osc_run && !cpu_clk_en |-> basic_timer_run
    && timer_counter_a_run)
    else $error("green mode timers stopped");
  AST_TCB_STOP: assert property (timer_counter_b_run == cpu_clk_en)
    else $error("counter b run differs from cpu run");
  AST_WDOG_STOP: assert property (watchdog_run == cpu_clk_en)
    else $error("watchdog run differs from cpu run");
  AST_SLEEP_STOP: assert property (!low_osc_run |-> !cpu_clk_en && !basic_timer_run
    && !timer_counter_a_run && !sys_clk_low_sel)
    else $error("sleep leaves logic running");
  AST_WAKE_CNT: assert property (warm_exit |-> warm_cnt_r >= wake_cycles
    && warm_cnt_r <= wake_cycles + 1 && !sys_clk_low_sel)
    else $error("sleep wake count wrong");
  AST_SLVERR: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  AST_INT_PULSE: assert property (port0_int |=> !port0_int)
    else $error("port 0 interrupt longer than one cycle");
endmodule

bind mode_wake_ctrl mode_wake_sva #(.wake_cycles(wake_cycles)) u_sva (.mclk, .reset_n,
  .psel, .penable, .pslverr, .high_osc_run, .low_osc_run, .sys_clk_low_sel, .cpu_clk_en,
  .instr_strobe, .basic_timer_run, .timer_counter_a_run, .timer_counter_b_run,
  .watchdog_run, .port0_int);

// *** bench/tb_top.sv ***
// self-checking bench for the mode and wakeup controller
// assumes apb with zero wait states and a short wake count
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module tb_top
  import mode_wake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int wk = 8;
  logic        mclk = 1'b0;
  logic        reset_n, psel, penable, pwrite, pready, pslverr, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0]  port0_pin;
  logic [4:0]  port1_pin;
  logic        basic_timer_timeout, high_osc_run, low_osc_run, sys_clk_low_sel, cpu_clk_en;
  logic        instr_strobe, basic_timer_run, timer_counter_a_run, timer_counter_b_run;
  logic        watchdog_run, port0_int;
  int          error_cnt, checks, n, k, int_cnt, mdl_edge, mdl_osc;
  logic [7:0]  regs [3] = '{edge_ctrl_idx, p1_mask_idx, osc_mode_idx};
  logic [7:0]  etab [6] = '{8'h80, 8'h88, 8'h90, 8'h98, 8'h00, 8'h98};
  int          xtab [6] = '{0, 1, 1, 2, 1, 2};

  always #5 mclk = ~mclk;

  mode_wake_ctrl #(.wake_cycles(wk)) u_mode_wake_ctrl (.mclk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .port0_pin, .port1_pin,
    .basic_timer_timeout, .high_osc_run, .low_osc_run, .sys_clk_low_sel, .cpu_clk_en,
    .instr_strobe, .basic_timer_run, .timer_counter_a_run, .timer_counter_b_run,
    .watchdog_run, .port0_int);
  wake_pins_model u_wake_pins_model (.mclk, .port0_pin, .port1_pin, .basic_timer_timeout);

  // count port 0 interrupt pulses
  always @(posedge mclk)
  begin
    if (port0_int === 1'b1)
      int_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task wrap_up();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one apb transfer, entered just after a rising edge
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge mclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (t >= 50)
    begin
      error_cnt++;
      wrap_up();
    end
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // mode outputs against the modelled mode register
  task mode_chk();
    `CHK(cpu_clk_en, 1'(mdl_osc[4:3] == 0))
    `CHK(low_osc_run, 1'(!mdl_osc[3]))
    `CHK(sys_clk_low_sel, 1'(mdl_osc[2] && !mdl_osc[3]))
    `CHK(high_osc_run, 1'(!(mdl_osc[1] && mdl_osc[2]) && !mdl_osc[3]))
    `CHK(basic_timer_run, 1'(!mdl_osc[3]))
    `CHK(timer_counter_a_run, 1'(!mdl_osc[3]))
    `CHK(timer_counter_b_run, 1'(mdl_osc[4:3] == 0))
    `CHK(watchdog_run, 1'(mdl_osc[4:3] == 0))
  endtask

  task osc_wr(input int d);
    apb(1'b1, osc_mode_idx, 32'(d));
    mdl_osc = d;
    repeat (2) @(posedge mclk);
    mode_chk();
  endtask

  // bounded wait for the cpu to run again
  // keep: mode bits that survive the wake (sleep drops slow select)
  task wake_wait(input int lim, input int keep);
    n = 0;
    while (cpu_clk_en !== 1'b1)
    begin
      @(posedge mclk);
      n++;
      if (n > lim)
      begin
        error_cnt++;
        wrap_up();
      end
    end
    mdl_osc = mdl_osc & keep;
    repeat (2) @(posedge mclk);
    mode_chk();
    apb(1'b0, osc_mode_idx, 32'h0);
    `CHK(q, 32'(mdl_osc))
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    int_cnt = 0;
    mdl_osc = 0;
    n = $urandom(30230);
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    mode_chk();
    `CHK(port0_int, 1'b0)
    // reset values, unmapped access, random register traffic
    foreach (regs[j])
    begin
      apb(1'b0, regs[j], 32'h0);
      `CHK(q, 32'h0)
    end
    apb(1'b1, 8'h10, 32'hff);
    `CHK(serr, 1'b1)
    apb(1'b0, 8'h10, 32'h0);
    `CHK(q, 32'h0)
    repeat (4)
    begin
      n = $urandom;
      apb(1'b1, edge_ctrl_idx, 32'(n));
      mdl_edge = n & 'h98;
      apb(1'b1, p1_mask_idx, 32'(n));
      apb(1'b0, edge_ctrl_idx, 32'h0);
      `CHK(q, 32'(mdl_edge))
      apb(1'b0, p1_mask_idx, 32'h0);
      `CHK(q, 32'h0)
    end
    // slow, high stop, green and back
    apb(1'b1, edge_ctrl_idx, 32'h0);
    apb(1'b1, timer_ctrl_idx, 32'h80);
    apb(1'b0, timer_ctrl_idx, 32'h0);
    `CHK(q, 32'h80)
    osc_wr('h04);
    osc_wr('h06);
    osc_wr('h16);
    `CHK(watchdog_run, 1'b0)
    `CHK(timer_counter_a_run, 1'b1)
    apb(1'b0, status_idx, 32'h0);
    `CHK(q, 32'h0000_0200)
    u_wake_pins_model.timeout_pulse();
    wake_wait(20, 'h06);
    osc_wr('h04);
    repeat (20) @(posedge mclk);
    osc_wr('h00);
    // count instruction strobes over a fixed window
    k = 0;
    repeat (40)
    begin
      @(posedge mclk);
      if (instr_strobe === 1'b1)
        k++;
    end
    `CHK(k, 40 / instr_div)
    apb(1'b1, timer_ctrl_idx, 32'h0);
    osc_wr('h10);
    u_wake_pins_model.timeout_pulse();
    repeat (10) @(posedge mclk);
    `CHK(cpu_clk_en, 1'b0)
    u_wake_pins_model.pins(2'h2, 5'h1f, 4);
    wake_wait(20, 'h06);
    // sleep: refused wakes, then port 1 and port 0 level wakes
    apb(1'b1, p1_mask_idx, 32'h01);
    for (k = 0; k < 2; k++)
    begin
      osc_wr(k ? 'h0c : 'h08);
      apb(1'b0, status_idx, 32'h0);
      `CHK(q, 32'h0000_0300)
      u_wake_pins_model.timeout_pulse();
      u_wake_pins_model.pins(2'h3, 5'h1d, 6);
      repeat (6) @(posedge mclk);
      `CHK(cpu_clk_en, 1'b0)
      u_wake_pins_model.pins(k ? 2'h2 : 2'h3, k ? 5'h1f : 5'h1e, 4);
      wake_wait(wk + 20, 'h02);
      `CHK(1'(n >= wk - 3), 1'b1)
    end
    // edge selects of pin 0.0, level mode, pin 0.1 any change
    for (k = 0; k < 6; k++)
    begin
      apb(1'b1, edge_ctrl_idx, 32'(etab[k]));
      int_cnt = 0;
      u_wake_pins_model.pins(k < 5 ? 2'h2 : 2'h1, 5'h1f, 6);
      repeat (6) @(posedge mclk);
      `CHK(int_cnt, xtab[k])
    end
    wrap_up();
  end
endmodule

// *** bench/wake_pins_model.sv ***
// wake pins and basic timer time-out seen by the controller
// assumes the bench calls its tasks right after a rising edge
module wake_pins_model
  import mode_wake_pkg::*;
(
  input  wire logic               mclk,
  output logic [p0_pins-1:0]      port0_pin,
  output logic [p1_pins-1:0]      port1_pin,
  output logic                    basic_timer_timeout
);
  timeunit 1ns;
  timeprecision 1ps;

  // pins idle high as if pulled up
  initial
  begin
    port0_pin = 2'h3;
    port1_pin = 5'h1f;
    basic_timer_timeout = 1'b0;
  end

  // hold a pin pattern for n cycles, then release
  task pins(input logic [1:0] p0, input logic [4:0] p1, input int n);
    @(posedge mclk);
    port0_pin <= p0;
    port1_pin <= p1;
    repeat (n) @(posedge mclk);
    port0_pin <= 2'h3;
    port1_pin <= 5'h1f;
  endtask

  // two-cycle time-out pulse
  task timeout_pulse();
    @(posedge mclk);
    basic_timer_timeout <= 1'b1;
    repeat (2) @(posedge mclk);
    basic_timer_timeout <= 1'b0;
  endtask
endmodule

// *** core/mode_wake_ctrl.sv ***
// operating mode and wakeup controller with apb register access
// assumes mclk is the high-speed oscillator clock and wake pins are async
//
// What this block does
// - normal mode runs cpu from high clock, one instruction per four periods
// - slow select one switches system clock to low clock, cpu keeps running
// - high stop bit stops only high oscillator, low clock keeps running
// - mode field 10 enters green, cpu halted, oscillators stay as before green
// - green keeps only basic timer and counter a, stops the rest
// - green exits on basic timer timeout, port wake, or reset
// - green exit returns to normal or slow, whichever was before
// - basic timer disabled gives no green wake
// - mode field 01 enters sleep, both oscillators and timers stop
// - sleep exits only on port wake or reset, then normal mode
// - sleep exit waits 2048 high clock cycles before running
// - clearing slow select with high oscillator running returns at once
// - port 0 always wakes; port 1 pins wake only when enabled
// - port 1 mask holds write-only enables for pins 0 to 4
// - edge enable zero: low level wake, pin 0.0 falling interrupt
// - edge enable one: pin 0.1 and port 1 any change, 0.0 by select
// - pin 0.0 select 01 fall, 10 rise, 11 both, 00 reserved
// - mode field bits 4:3: 00 normal, 01 sleep, 10 green
//
// Our own choice: the APB register port.
module mode_wake_ctrl
  import mode_wake_pkg::*;
#(
  parameter int wake_cycles = wake_count_cycles
)(
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  input  wire logic [p0_pins-1:0]  port0_pin,
  input  wire logic [p1_pins-1:0]  port1_pin,
  input  wire logic                basic_timer_timeout,
  output logic                     high_osc_run,
  output logic                     low_osc_run,
  output logic                     sys_clk_low_sel,
  output logic                     cpu_clk_en,
  output logic                     instr_strobe,
  output logic                     basic_timer_run,
  output logic                     timer_counter_a_run,
  output logic                     timer_counter_b_run,
  output logic                     watchdog_run,
  output logic                     port0_int
);

  // counter wide enough to hold the full settle count
  localparam int wcnt_w = $clog2(wake_cycles + 1);
  localparam logic [wcnt_w-1:0] wcnt_last = wcnt_w'(wake_cycles - 1);

  // control registers, synchronisers and mode state
  logic [7:0]         osc_mode_r;
  logic [7:0]         edge_ctrl_r;
  logic [7:0]         p1_mask_r;
  logic [7:0]         timer_ctrl_r;
  logic [p0_pins-1:0] p0_meta_r;
  logic [p0_pins-1:0] p0_sync_r;
  logic [p0_pins-1:0] p0_prev_r;
  logic [p1_pins-1:0] p1_meta_r;
  logic [p1_pins-1:0] p1_sync_r;
  logic [p1_pins-1:0] p1_prev_r;
  logic               bt_meta_r;
  logic               bt_sync_r;
  sys_state_t         state_r;
  sys_state_t         state_nxt;
  logic               green_from_slow_r;
  logic [wcnt_w-1:0]  wcnt_r;
  logic [1:0]         div_r;
  // combinational decode and trigger terms
  logic [p0_pins-1:0] p0_trig;
  logic [p1_pins-1:0] p1_trig;
  logic               port_wake;
  logic               bt_wake;
  logic               wr_en;
  logic               rd_en;
  logic               addr_hit;
  logic [7:0]         word_idx;
  logic [1:0]         cpu_mode;
  logic [1:0]         p00_sel;
  logic               edge_en;
  logic               p0_fall0;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait state, word index is byte address / 4

  assign word_idx = paddr[9:2];
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign addr_hit = (word_idx == edge_ctrl_idx) || (word_idx == p1_mask_idx) ||
                    (word_idx == osc_mode_idx) || (word_idx == timer_ctrl_idx) ||
                    (word_idx == status_idx);
  // no wait states: every access ends in its first access cycle
  assign pready   = 1'b1;
  // unmapped word flags an error and the write is dropped
  assign pslverr  = psel && penable && !addr_hit;

  // field views of the control registers
  assign cpu_mode = {osc_mode_r[cpu_mode_hi_bit], osc_mode_r[cpu_mode_lo_bit]};
  assign p00_sel  = {edge_ctrl_r[edge_sel_hi_bit], edge_ctrl_r[edge_sel_lo_bit]};
  assign edge_en  = edge_ctrl_r[edge_trigger_enable_bit];

  // oscillator mode register; mode field self-clears on wakeup
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      osc_mode_r <= osc_mode_rst;
    else if (wr_en && word_idx == osc_mode_idx)
      osc_mode_r <= pwdata[7:0] & osc_mode_wmask;
    // mode bits drop when sleep or green ends
    else if ((state_r == st_green || state_r == st_sleep) && state_nxt != state_r)
    begin
      osc_mode_r[cpu_mode_hi_bit] <= 1'b0;
      osc_mode_r[cpu_mode_lo_bit] <= 1'b0;
      // sleep always wakes into normal, never slow
      if (state_r == st_sleep)
        osc_mode_r[slow_clock_select_bit] <= 1'b0;
    end
  end

  // edge control register
  // select bits kept while edge enable is off
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      edge_ctrl_r <= edge_ctrl_rst;
    else if (wr_en && word_idx == edge_ctrl_idx)
      edge_ctrl_r <= pwdata[7:0] & edge_ctrl_wmask;
  end

  // port 1 wake mask, write only
  // reads return zero, software keeps its own copy
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      p1_mask_r <= p1_mask_rst;
    else if (wr_en && word_idx == p1_mask_idx)
      p1_mask_r <= pwdata[7:0] & p1_mask_wmask;
  end

  // basic timer control, enable bit only used here
  // other bits stored for software read-back
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      timer_ctrl_r <= timer_ctrl_rst;
    else if (wr_en && word_idx == timer_ctrl_idx)
      timer_ctrl_r <= pwdata[7:0];
  end

  // read data registered in setup phase
  // status read shows the mode at the setup edge
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (word_idx)
        edge_ctrl_idx:  prdata <= {24'h000000, edge_ctrl_r};
        osc_mode_idx:   prdata <= {24'h000000, osc_mode_r};
        timer_ctrl_idx: prdata <= {24'h000000, timer_ctrl_r};
        status_idx:     prdata <= {21'h0, 3'(state_r), 8'h00};
        default:        prdata <= 32'h0000_0000; // mask reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and previous-value stage

  // two flops per pin against metastability, third stage for edges
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      p0_meta_r <= '1;
      p0_sync_r <= '1;
      p0_prev_r <= '1;
      p1_meta_r <= '1;
      p1_sync_r <= '1;
      p1_prev_r <= '1;
      bt_meta_r <= 1'b0;
      bt_sync_r <= 1'b0;
    end
    else
    begin
      p0_meta_r <= port0_pin;
      p0_sync_r <= p0_meta_r;
      p0_prev_r <= p0_sync_r;
      p1_meta_r <= port1_pin;
      p1_sync_r <= p1_meta_r;
      p1_prev_r <= p1_sync_r;
      bt_meta_r <= basic_timer_timeout;
      bt_sync_r <= bt_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake trigger detection

  // falling edge of pin 0.0, shared by interrupt and select
  assign p0_fall0 = p0_prev_r[0] && !p0_sync_r[0];

  always_comb
  begin
    p0_trig = '0;
    if (!edge_en)
      p0_trig = ~p0_sync_r;
    else
    begin
      p0_trig[1] = p0_prev_r[1] ^ p0_sync_r[1];
      case (p00_sel)
        sel_fall: p0_trig[0] = p0_fall0;
        sel_rise: p0_trig[0] = !p0_prev_r[0] && p0_sync_r[0];
        sel_both: p0_trig[0] = p0_prev_r[0] ^ p0_sync_r[0];
        default:  p0_trig[0] = 1'b0;
      endcase
    end
  end

  // port 1 gated per pin by mask
  genvar gi;
  generate
    for (gi = 0; gi < p1_pins; gi++)
    begin : g_p1
      assign p1_trig[gi] = p1_mask_r[gi] &&
                           (edge_en ? (p1_prev_r[gi] ^ p1_sync_r[gi]) : !p1_sync_r[gi]);
    end
  endgenerate

  // any armed pin wakes
  assign port_wake = |p0_trig || |p1_trig;
  // disabled basic timer gives no wake
  assign bt_wake   = bt_sync_r && timer_ctrl_r[basic_timer_enable_bit];

  // port 0 interrupt on pin 0.0 falling edge, or in edge mode pin 0.0 as selected plus any pin 0.1 change
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      port0_int <= 1'b0;
    else if (!edge_en)
      port0_int <= p0_fall0;
    else
      port0_int <= p0_trig[0] || p0_trig[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine

  // next mode from control field and wake sources
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_normal, st_slow:
      begin
        if (cpu_mode == cpu_sleep)
          state_nxt = st_sleep;
        else if (cpu_mode == cpu_green)
          state_nxt = st_green;
        else if (osc_mode_r[slow_clock_select_bit])
          state_nxt = st_slow;
        else
          state_nxt = st_normal;
      end
      st_green:
      begin
        // timer or port wake; last mode
        if (bt_wake || port_wake)
          state_nxt = green_from_slow_r ? st_slow : st_normal;
      end
      st_sleep:
      begin
        if (port_wake)
          state_nxt = st_warmup;
      end
      st_warmup:
      begin
        if (wcnt_r == wcnt_last)
          state_nxt = st_normal;
      end
      default: state_nxt = st_normal;
    endcase
  end

  // current mode register
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      state_r <= st_normal;
    else
      state_r <= state_nxt;
  end

  // remembers mode before green
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      green_from_slow_r <= 1'b0;
    else if (state_nxt == st_green && state_r != st_green)
      green_from_slow_r <= (state_r == st_slow);
  end

  // wake settle counter
  // a stale count would shorten the next settle time
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      wcnt_r <= '0;
    else if (state_r != st_warmup)
      wcnt_r <= '0;
    else
      wcnt_r <= wcnt_r + wcnt_w'(1);
  end

  // instruction divider, four clocks per instruction
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      div_r <= 2'h0;
    else if (!cpu_clk_en)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock and peripheral enables

  // divider restarts on resume, so first strobe comes three clocks later
  // one strobe per four high clock periods
  assign instr_strobe    = cpu_clk_en && (div_r == 2'(instr_div - 1));
  assign cpu_clk_en      = (state_r == st_normal) || (state_r == st_slow);
  assign sys_clk_low_sel = (state_r == st_slow) ||
                           (state_r == st_green && green_from_slow_r);
  // high oscillator restarts during the settle count
  // stop bit affects only high oscillator; sleep stops both
  assign high_osc_run    = (state_r == st_warmup) || ((state_r != st_sleep) &&
                           !(osc_mode_r[high_osc_stop_bit] && sys_clk_low_sel));
  // low oscillator off in sleep and warmup
  assign low_osc_run     = (state_r != st_sleep) && (state_r != st_warmup);
  // green keeps only basic timer and counter a
  assign basic_timer_run     = (state_r != st_sleep) && (state_r != st_warmup);
  assign timer_counter_a_run = basic_timer_run;
  // counter b and watchdog halt with the cpu
  assign timer_counter_b_run = cpu_clk_en;
  assign watchdog_run        = cpu_clk_en;

endmodule

// *** core/mode_wake_pkg.sv ***
// constants for the operating mode and wakeup controller
// assumes an apb slave with 32-bit data and byte addresses
package mode_wake_pkg;

  // register word indices (printed offsets kept as indices)
  localparam logic [7:0] edge_ctrl_idx   = 8'hbf;
  localparam logic [7:0] p1_mask_idx     = 8'hc0;
  localparam logic [7:0] osc_mode_idx    = 8'hca;
  localparam logic [7:0] timer_ctrl_idx  = 8'hd8;
  localparam logic [7:0] status_idx      = 8'hd0;

  // osc mode fields
  localparam int high_osc_stop_bit      = 1;
  localparam int slow_clock_select_bit  = 2;
  localparam int cpu_mode_lo_bit        = 3;
  localparam int cpu_mode_hi_bit        = 4;

  // edge control fields
  localparam int edge_trigger_enable_bit = 7;
  localparam int edge_sel_lo_bit         = 3;
  localparam int edge_sel_hi_bit         = 4;

  // timer control field
  localparam int basic_timer_enable_bit = 7;

  // widths and reset values
  localparam int p1_pins               = 5;
  localparam int p0_pins               = 2;
  localparam logic [7:0] osc_mode_rst  = 8'h00;
  localparam logic [7:0] edge_ctrl_rst = 8'h00;
  localparam logic [7:0] p1_mask_rst   = 8'h00;
  localparam logic [7:0] timer_ctrl_rst = 8'h00;
  localparam logic [7:0] osc_mode_wmask = 8'hfe;
  localparam logic [7:0] edge_ctrl_wmask = 8'h98;
  localparam logic [7:0] p1_mask_wmask  = 8'h1f;

  // cpu mode field encodings
  localparam logic [1:0] cpu_normal = 2'h0;
  localparam logic [1:0] cpu_sleep  = 2'h1;
  localparam logic [1:0] cpu_green  = 2'h2;

  // pin 0.0 edge select encodings
  localparam logic [1:0] sel_fall = 2'h1;
  localparam logic [1:0] sel_rise = 2'h2;
  localparam logic [1:0] sel_both = 2'h3;

  // high-speed clock cycles per instruction and sleep wake count
  localparam int instr_div         = 4;
  localparam int wake_count_cycles = 2048;

  typedef enum logic [2:0] {
    st_normal,
    st_slow,
    st_green,
    st_sleep,
    st_warmup
  } sys_state_t;

endpackage
